// >>> dbk_pkg.sv
// Package: register map, field positions and types for the breakpoint control block
package dbk_pkg;
	localparam logic [7:0] ADDR_MATCH0_LOW = 8'h00;
	localparam logic [7:0] ADDR_MATCH0_HIGH = 8'h01;
	localparam logic [7:0] ADDR_MATCH0_UPPER = 8'h02;
	localparam logic [7:0] ADDR_MATCH_STRIDE = 8'h04;
	localparam logic [7:0] ADDR_MATCH_LAST = 8'h0e;
	localparam logic [7:0] ADDR_BREAKPOINT_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_DEBUG_MASTER_CONTROL = 8'h11;
	localparam int BIT_BREAK_NEXT = 7;
	localparam int BIT_MATCH3_ENABLE = 6;
	localparam int BIT_MATCH2_ENABLE = 5;
	localparam int BIT_MATCH1_ENABLE = 4;
	localparam int BIT_MATCH0_ENABLE = 3;
	localparam int BIT_IGNORE_LOW1 = 2;
	localparam int BIT_IGNORE_LOW0 = 1;
	localparam int BIT_SINGLE_STEP = 0;
	localparam int BIT_CPU_RESET_REQUEST = 7;
	localparam int BIT_WAKE_REQUEST = 0;
	localparam logic [7:0] BREAKPOINT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] DEBUG_MASTER_CONTROL_RESET = 8'h00;
	localparam int MATCH_COUNT = 4;
	localparam int CPU_RESET_NS = 100;
	localparam int MCLK_NS = 10;
	localparam int CPU_RESET_CYCLES = (CPU_RESET_NS + MCLK_NS - 1) / MCLK_NS;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} dbk_wr_t;

	typedef struct packed {
		logic fetch;
		logic first_opcode;
		logic instr_done;
		logic long_address_mode;
		logic [7:0] memory_base_reg;
		logic [23:0] addr;
	} dbk_cpu_t;
endpackage : dbk_pkg

// >>> dbk_match_mem.sv
// Match address store: twelve write-only bytes with registered read
`timescale 1ns/10ps
module dbk_match_mem (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic [7:0] wdata_i,
	output logic [95:0] rdata_o
);
	import dbk_pkg::*;
	logic [7:0] mem [0:15];

	always_ff @(posedge mclk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// All four comparators read every enabled cycle, so the whole store comes out registered
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < MATCH_COUNT; i++) begin
				rdata_o[i*24 +: 24] <= {mem[i*4+2], mem[i*4+1], mem[i*4]};
			end
		end
	end
endmodule : dbk_match_mem

// >>> dbk_break_ctrl.sv
// Breakpoint control: link-side register writes, address comparators, break and reset control
//
// Behaviour
// - Writing 0 to break-next releases the CPU and disables next-instruction break.
// - Breaks land on the first opcode byte of an instruction or when an instruction completes.
// - Clock pin high, data pin low at reset end sets break-next.
// - Any enabled address-match break sets break-next automatically.
// - Writing 1 to break-next forces a break on the next instruction.
// - Bits 6 to 3 enable comparators 3 to 0.
// - Unmasked comparator matches the full 24-bit address.
// - Mask bit 2 makes comparator 1 match address bits 23 to 8.
// - Mask bit 1 makes comparator 0 match address bits 23 to 8.
// - Single-step bit breaks after every executed instruction.
// - Master control can reset the CPU and wake it from low power.
// - Compared address is full in long mode, base plus 16 bits otherwise.
// - A match inside an instruction breaks once the instruction completes.
// - Reset-request bit starts a CPU reset and clears itself at the end.
`timescale 1ns/10ps
module dbk_break_ctrl (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic link_clk_i,
	input wire logic link_rst_n_i,
	input wire dbk_pkg::dbk_wr_t link_wr_i,
	input wire logic link_wr_valid_i,
	input wire logic debug_clock_pin_i,
	input wire logic debug_data_pin_i,
	input wire dbk_pkg::dbk_cpu_t cpu_i,
	input wire logic cpu_low_power_i,
	output logic cpu_break_o,
	output logic cpu_reset_o,
	output logic cpu_wake_o,
	output logic [7:0] status_o
);
	import dbk_pkg::*;

	typedef enum logic [1:0] {ST_RUN, ST_PENDING, ST_HALTED} dbk_state_t;

	// Link side: hold the written byte and flip a toggle, words cross by handshake-free hold
	dbk_wr_t link_hold;
	logic link_toggle;
	always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			link_hold <= '0;
		end else if (link_wr_valid_i) begin
			link_hold <= link_wr_i;
		end
	end

	always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			link_toggle <= 1'b0;
		end else if (link_wr_valid_i) begin
			link_toggle <= ~link_toggle;
		end
	end

	// Reset release through two flops
	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Write toggle synchronised; the hold word is stable long before the toggle lands
	logic tog_meta;
	logic tog_sync;
	logic tog_seen;
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
		end else if (ce_i) begin
			tog_meta <= link_toggle;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
		end
	end

	// No reset here, so the pin levels are already settled when reset ends
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			pin_meta <= {debug_data_pin_i, debug_clock_pin_i};
			pin_sync <= pin_meta;
		end
	end

	logic wr_stb;
	dbk_wr_t wr;
	assign wr_stb = tog_sync ^ tog_seen;
	assign wr = link_hold;

	function automatic logic is_match_byte(input logic [7:0] a);
		is_match_byte = (a <= ADDR_MATCH_LAST) && (a[1:0] != 2'b11);
	endfunction : is_match_byte

	// Register select shared by control and master writes
	function automatic logic reg_hit(input logic stb, input logic [7:0] a, input logic [7:0] sel);
		reg_hit = stb && (a == sel);
	endfunction : reg_hit

	logic wr_ctl;
	logic wr_master;
	assign wr_ctl = reg_hit(wr_stb, wr.addr, ADDR_BREAKPOINT_CONTROL);
	assign wr_master = reg_hit(wr_stb, wr.addr, ADDR_DEBUG_MASTER_CONTROL);

	logic [95:0] match_bytes;
	dbk_match_mem u_match_mem (
		.mclk_i(mclk_i),
		.rst_n_i(rst_sync_n),
		.ce_i(ce_i),
		.we_i(wr_stb && is_match_byte(wr.addr)),
		.waddr_i(wr.addr[3:0]),
		.wdata_i(wr.data),
		.rdata_o(match_bytes)
	);

	// Strap capture one cycle after reset release
	logic strap_done;
	logic strap_break;
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			strap_done <= 1'b0;
		end else if (ce_i) begin
			strap_done <= 1'b1;
		end
	end

	// Only the first enabled cycle looks at the pins
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			strap_break <= 1'b0;
		end else if (ce_i) begin
			strap_break <= !strap_done && pin_sync[0] && !pin_sync[1];
		end
	end

	// Address under comparison
	logic [23:0] cpu_addr;
	assign cpu_addr = cpu_i.long_address_mode ? cpu_i.addr : {cpu_i.memory_base_reg, cpu_i.addr[15:0]};

	function automatic logic addr_hit(input logic [23:0] a, input logic [23:0] ref_a, input logic ign_low);
		addr_hit = (a[23:8] == ref_a[23:8]) && (ign_low || a[7:0] == ref_a[7:0]);
	endfunction : addr_hit

	logic [7:0] ctl;
	logic [MATCH_COUNT-1:0] hits;
	always_comb begin
		for (int i = 0; i < MATCH_COUNT; i++) begin
			hits[i] = ctl[BIT_MATCH0_ENABLE + i] && cpu_i.fetch
				&& addr_hit(cpu_addr, match_bytes[i*24 +: 24], 1'b0);
		end
		hits[1] = ctl[BIT_MATCH1_ENABLE] && cpu_i.fetch
			&& addr_hit(cpu_addr, match_bytes[47:24], ctl[BIT_IGNORE_LOW1]);
		hits[0] = ctl[BIT_MATCH0_ENABLE] && cpu_i.fetch
			&& addr_hit(cpu_addr, match_bytes[23:0], ctl[BIT_IGNORE_LOW0]);
	end

	// Break sequencing
	dbk_state_t state;
	dbk_state_t next_state;
	logic any_hit;
	logic take_break;
	assign any_hit = |hits;
	// Ending on first opcode keeps a break off operand bytes
	assign take_break = cpu_i.fetch && cpu_i.first_opcode;

	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (ctl[BIT_BREAK_NEXT] && take_break) begin
					next_state = ST_HALTED;
				end else if (any_hit && take_break) begin
					next_state = ST_HALTED;
				end else if (any_hit) begin
					next_state = ST_PENDING;
				end else if (ctl[BIT_SINGLE_STEP] && cpu_i.instr_done) begin
					next_state = ST_HALTED;
				end
			end
			ST_PENDING: begin
				if (cpu_i.instr_done) begin
					next_state = ST_HALTED;
				end
			end
			ST_HALTED: begin
				if (!ctl[BIT_BREAK_NEXT]) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_RUN;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// Control register; hardware set wins over a host clear in the same cycle
	logic hw_set_next;
	assign hw_set_next = strap_break || (state != ST_HALTED && next_state == ST_HALTED);
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctl <= BREAKPOINT_CONTROL_RESET;
		end else if (ce_i) begin
			if (wr_ctl) begin
				ctl <= wr.data;
			end
			if (hw_set_next) begin
				ctl[BIT_BREAK_NEXT] <= 1'b1;
			end
		end
	end

	// Master control: reset pulse of fixed length; a pulse in flight is not restarted
	localparam int RST_CNT_W = $clog2(CPU_RESET_CYCLES + 1);
	logic reset_req;
	logic wake_req;
	logic start_reset;
	logic [RST_CNT_W-1:0] rst_cnt;
	assign start_reset = wr_master && wr.data[BIT_CPU_RESET_REQUEST] && !reset_req;

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rst_cnt <= '0;
		end else if (ce_i) begin
			if (start_reset) begin
				rst_cnt <= RST_CNT_W'(CPU_RESET_CYCLES);
			end else if (rst_cnt != '0) begin
				rst_cnt <= rst_cnt - 1'b1;
			end
		end
	end

	// Cleared by hardware at the end of the pulse
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reset_req <= DEBUG_MASTER_CONTROL_RESET[BIT_CPU_RESET_REQUEST];
		end else if (ce_i) begin
			if (start_reset) begin
				reset_req <= 1'b1;
			end else if (rst_cnt == RST_CNT_W'(1)) begin
				reset_req <= 1'b0;
			end
		end
	end

	// Wake request on any master write; the output passes it only in low power
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wake_req <= 1'b0;
		end else if (ce_i) begin
			wake_req <= wr_master;
		end
	end

	// Each output has its own flop so the CPU side sees clean levels
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cpu_break_o <= 1'b0;
		end else if (ce_i) begin
			cpu_break_o <= (next_state == ST_HALTED);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cpu_reset_o <= 1'b0;
		end else if (ce_i) begin
			cpu_reset_o <= reset_req;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cpu_wake_o <= 1'b0;
		end else if (ce_i) begin
			cpu_wake_o <= wake_req && cpu_low_power_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status_o <= '0;
		end else if (ce_i) begin
			status_o <= {ctl[BIT_BREAK_NEXT], reset_req, 4'h0, state};
		end
	end
endmodule : dbk_break_ctrl

// >>> dbk_host.sv
// Host model: drives register writes over the link, clock idle between frames
`timescale 1ns/10ps
module dbk_host (
	output logic link_clk_o,
	output dbk_pkg::dbk_wr_t link_wr_o,
	output logic link_wr_valid_o
);
	import dbk_pkg::*;
	initial begin
		link_clk_o = 1'b0;
		link_wr_o = 16'h0000;
		link_wr_valid_o = 1'b0;
	end
	// Odd offset keeps link edges off the main clock edges
	task automatic send(input logic [7:0] a, input logic [7:0] d);
		link_wr_o = {a, d};
		link_wr_valid_o = 1'b1;
		#43 link_clk_o = 1'b1;
		#40 link_clk_o = 1'b0;
		link_wr_valid_o = 1'b0;
		link_wr_o = ~{a, d};
		#40 link_clk_o = 1'b1;
		#40 link_clk_o = 1'b0;
	endtask : send
endmodule : dbk_host

// >>> dbk_break_ctrl_checker.sv
// Checker: break, reset and wake timing at the block ports
`timescale 1ns/10ps
module dbk_break_ctrl_checker (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire dbk_pkg::dbk_cpu_t cpu_i,
	input wire logic cpu_break_o,
	input wire logic cpu_reset_o,
	input wire logic cpu_wake_o,
	input wire logic [7:0] status_o
);
	import dbk_pkg::*;
	wire ev = (cpu_i.fetch & cpu_i.first_opcode) | cpu_i.instr_done;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	rst_len_a: assert property ($rose(cpu_reset_o) |-> cpu_reset_o[*8] ##1 cpu_reset_o[*2] ##1 !cpu_reset_o)
		else $error("cpu reset length wrong");
	rst_clear_a: assert property ($fell(cpu_reset_o) |-> ##[0:1] !status_o[6])
		else $error("reset request not cleared");
	rst_start_a: assert property ($rose(status_o[6]) |-> ##[0:2] cpu_reset_o)
		else $error("reset request without cpu reset");
	brk_boundary_a: assert property ($rose(cpu_break_o) |-> $past(ev) || $past(ev, 2))
		else $error("break off an instruction boundary");
	brk_release_a: assert property ($fell(cpu_break_o) |-> ##[0:2] !status_o[7])
		else $error("break dropped while break-next set");
	brk_clear_a: assert property ($fell(status_o[7]) |-> ##[0:2] !cpu_break_o)
		else $error("break held after clear");
	brk_flag_a: assert property ($rose(cpu_break_o) && $past(cpu_i.first_opcode) |-> ##[0:2] status_o[7])
		else $error("break-next not set by break");
	wake_pulse_a: assert property (cpu_wake_o |=> !cpu_wake_o)
		else $error("wake longer than one cycle");
	cover property ($rose(cpu_break_o));
	cover property ($rose(cpu_reset_o));
	cover property (cpu_wake_o);
endmodule : dbk_break_ctrl_checker
bind dbk_break_ctrl dbk_break_ctrl_checker i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cpu_i(cpu_i),
	.cpu_break_o(cpu_break_o), .cpu_reset_o(cpu_reset_o), .cpu_wake_o(cpu_wake_o), .status_o(status_o));

// >>> tb.sv
// Testbench: host writes, CPU fetch stimulus, break and reset checks
`timescale 1ns/10ps
module tb;
	import dbk_pkg::*;
	logic mclk_i = 1'b0, rst_n_i, ce_i, link_rst_n_i, debug_clock_pin_i, debug_data_pin_i, cpu_low_power_i;
	logic link_clk, link_wr_valid, cpu_break_o, cpu_reset_o, cpu_wake_o;
	logic [7:0] status_o;
	dbk_wr_t link_wr;
	dbk_cpu_t cpu_i;
	logic [23:0] ad [4];
	int bad_count = 0, tests_run = 0, rst_cnt = 0, wake_cnt = 0;
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		rst_cnt <= rst_cnt + int'(cpu_reset_o === 1'b1);
		wake_cnt <= wake_cnt + int'(cpu_wake_o === 1'b1);
	end
	dbk_host i_host (.link_clk_o(link_clk), .link_wr_o(link_wr), .link_wr_valid_o(link_wr_valid));
	dbk_break_ctrl i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link_clk_i(link_clk),
		.link_rst_n_i(link_rst_n_i), .link_wr_i(link_wr), .link_wr_valid_i(link_wr_valid),
		.debug_clock_pin_i(debug_clock_pin_i), .debug_data_pin_i(debug_data_pin_i), .cpu_i(cpu_i),
		.cpu_low_power_i(cpu_low_power_i), .cpu_break_o(cpu_break_o), .cpu_reset_o(cpu_reset_o),
		.cpu_wake_o(cpu_wake_o), .status_o(status_o));
	task automatic chk(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %b want %b", $time, g, e);
		end
	endtask : chk
	// Crossing takes a few main cycles after the link edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.send(a, d);
		repeat (4) @(posedge mclk_i);
	endtask : wr
	task automatic cyc(input dbk_cpu_t v);
		@(posedge mclk_i);
		cpu_i <= v;
		@(posedge mclk_i);
		cpu_i <= '0;
		repeat (3) @(posedge mclk_i);
	endtask : cyc
	task automatic ins(input logic fo, input logic [23:0] a);
		cyc({1'b1, fo, 1'b0, 1'b1, 8'h00, a});
	endtask : ins
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial begin
		#50us;
		bad_count++;
		summarize();
	end
	initial begin
		rst_n_i = 1'b0;
		link_rst_n_i = 1'b0;
		ce_i = 1'b1;
		debug_clock_pin_i = 1'b1;
		debug_data_pin_i = 1'b0;
		cpu_i = '0;
		cpu_low_power_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		link_rst_n_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk(status_o[7], 1'b1);
		ins(1'b1, 24'h000000);
		chk(cpu_break_o, 1'b1);
		ins(1'b1, 24'h000003);
		chk(cpu_break_o, 1'b1);
		wr(8'h10, 8'h00);
		chk(cpu_break_o, 1'b0);
		wr(8'h10, 8'h80);
		ins(1'b0, 24'h000010);
		chk(cpu_break_o, 1'b0);
		ins(1'b1, 24'h000012);
		chk(cpu_break_o, 1'b1);
		wr(8'h10, 8'h00);
		$display("test strap and force done");
		for (int n = 0; n < 4; n++) begin
			ad[n] = 24'h3a5000 + 24'(n * 24'h010101);
			wr(8'(4 * n + 2), ad[n][23:16]);
			wr(8'(4 * n + 1), ad[n][15:8]);
			wr(8'(4 * n), ad[n][7:0]);
		end
		for (int n = 0; n < 4; n++) begin
			wr(8'h10, 8'(8 << ((n + 1) % 4)));
			ins(1'b1, ad[n]);
			chk(cpu_break_o, 1'b0);
			wr(8'h10, 8'(8 << n));
			ins(1'b1, ad[n] ^ 24'h000001);
			chk(cpu_break_o, 1'b0);
			ins(1'b1, ad[n]);
			chk(cpu_break_o, 1'b1);
			chk(status_o[7], 1'b1);
			wr(8'h10, 8'h00);
		end
		for (int m = 0; m < 2; m++) begin
			wr(8'h10, m ? 8'h14 : 8'h0a);
			ins(1'b1, ad[m] ^ 24'h000100);
			chk(cpu_break_o, 1'b0);
			ins(1'b1, ad[m] ^ 24'h0000ff);
			chk(cpu_break_o, 1'b1);
			wr(8'h10, 8'h00);
		end
		$display("test comparators done");
		wr(8'h10, 8'h20);
		cyc({4'h8, ad[2][23:16], 8'h5c, ad[2][15:0]});
		chk(cpu_break_o, 1'b0);
		chk(status_o[1:0] == 2'h1, 1'b1);
		cyc({4'h2, 8'h00, 24'h000000});
		chk(cpu_break_o, 1'b1);
		wr(8'h10, 8'h01);
		chk(cpu_break_o, 1'b0);
		cyc({4'h2, 8'h00, 24'h000000});
		chk(cpu_break_o, 1'b1);
		wr(8'h10, 8'h00);
		cyc({4'h2, 8'h00, 24'h000000});
		chk(cpu_break_o, 1'b0);
		$display("test step and deferred done");
		ce_i <= 1'b0;
		wr(8'h10, 8'h80);
		chk(status_o[7], 1'b0);
		ce_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		chk(status_o[7], 1'b1);
		wr(8'h10, 8'h00);
		chk(status_o[7], 1'b0);
		$display("test clock enable done");
		wr(8'h11, 8'h80);
		repeat (12) @(posedge mclk_i);
		chk(rst_cnt == CPU_RESET_CYCLES, 1'b1);
		chk(status_o[6], 1'b0);
		chk(wake_cnt == 0, 1'b1);
		cpu_low_power_i <= 1'b1;
		wr(8'h11, 8'h01);
		chk(wake_cnt == 1, 1'b1);
		$display("test master control done");
		summarize();
	end
endmodule : tb
